// file: dpc_regs.svh
// Purpose: timing constants for the dual potentiometer host controller
// Assumes: core clock of 250 MHz (4 ns period)
// Notes: least times round up to whole cycles
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define DPC_CLK_PS 4000
// ----------------------------------------------------------------------
// pin timing, in their own units
// ----------------------------------------------------------------------
`define DPC_T_SETUP_NS 100
`define DPC_T_HALF_NS 1000
`define DPC_T_DESEL_NS 250
`define DPC_T_STORE_MS 10
// ----------------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------------
`define DPC_SETUP_CYC ((`DPC_T_SETUP_NS*1000+`DPC_CLK_PS-1)/`DPC_CLK_PS)
`define DPC_HALF_CYC ((`DPC_T_HALF_NS*1000+`DPC_CLK_PS-1)/`DPC_CLK_PS)
`define DPC_DESEL_CYC ((`DPC_T_DESEL_NS*1000+`DPC_CLK_PS-1)/`DPC_CLK_PS)
// store time counted in ns so the product stays inside 32 bits
`define DPC_STORE_CYC ((`DPC_T_STORE_MS*1000000+`DPC_CLK_PS/1000-1)/(`DPC_CLK_PS/1000))
// ----------------------------------------------------------------------
// wiper position width and top value
// ----------------------------------------------------------------------
`define DPC_POS_W 5
`define DPC_POS_MAX 5'h1F
`endif

// file: dpc_pkg.sv
// Purpose: types for the dual potentiometer host controller
// Assumes: nothing beyond the timing header
// Notes: one command moves one channel and optionally stores
package dpc_pkg;
  // host request for one channel
  typedef struct packed {
    logic up;          // direction of each step
    logic [4:0] steps; // number of steps, zero with store is a plain store/deselect, without store only the direction pin takes up
    logic store;       // deselect with step strobe high to store
  } dpc_cmd_t;
  // pin group of one channel
  typedef struct packed {
    logic sel_n;
    logic step_n;
    logic up;
  } dpc_pins_t;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SEL   = 7'h02,
    ST_LOW   = 7'h04,
    ST_HIGH  = 7'h08,
    ST_PRE   = 7'h10,
    ST_DESEL = 7'h20,
    ST_WAIT  = 7'h40
  } dpc_state_t;
endpackage

// file: dpc_host.sv
// Purpose: host that drives select, step and direction pins of two
//   potentiometer channels
// Assumes: single 250 MHz clock; pins are outputs only
// Notes: each channel has its own sequencer; a tracked position copy
//   counts the device steps from zero after reset, saturating like the device does;
//   a no-store command leaves the strobe low until the next select,
//   so no strobe edge is ever made while a channel is deselected
//
// How it works
// - no store: last strobe low phase held while select rises
// - select outputs are high from reset onward
// - direction loads only as a command is taken, on the same edge that lowers select (select stays high for zero steps without store)
// - never raise select at the same cycle as a step falling edge
// - select held high ten milliseconds after a storing deselect
`timescale 1ns/1ps
`include "dpc_regs.svh"
module dpc_host
  import dpc_pkg::*;
#(
  parameter int STORE_CYC = `DPC_STORE_CYC,
  parameter int HALF_CYC = `DPC_HALF_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // command side, one per channel
  input wire logic [1:0] cmd_valid,
  input dpc_cmd_t cmd [2],
  output logic [1:0] cmd_ready,
  output logic [1:0] pos_known,
  output logic [9:0] pos,
  // device pins
  output dpc_pins_t pins [2]
);
  localparam int SETUP_CYC = `DPC_SETUP_CYC;
  localparam int DESEL_CYC = `DPC_DESEL_CYC;
  localparam int CW = 24;

  // refuse timings the counter cannot hold or that break the setup time
  if (STORE_CYC < 1 || HALF_CYC < SETUP_CYC || STORE_CYC >= (1 << CW) ||
      HALF_CYC >= (1 << CW))
  begin : gen_bad_timing
    $error("dpc_host: timing parameters out of range");
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_ch
      dpc_state_t st_q, st_d;
      logic [CW-1:0] cnt_q, cnt_d;
      logic [4:0] left_q, left_d;
      logic up_q, up_d;
      logic store_q, store_d;
      logic sel_n_q, sel_n_d;
      logic step_n_q, step_n_d;
      logic [4:0] pos_q, pos_d;
      logic known_q, known_d;
      logic ready_q, ready_d;

      // next-state for one channel sequencer
      always_comb
      begin
        st_d = st_q;
        cnt_d = cnt_q;
        left_d = left_q;
        up_d = up_q;
        store_d = store_q;
        sel_n_d = sel_n_q;
        step_n_d = step_n_q;
        pos_d = pos_q;
        known_d = known_q;
        ready_d = ready_q;
        if (cnt_q != '0)
          cnt_d = cnt_q - CW'(1);
        case (st_q)
          ST_IDLE:
          begin
            ready_d = 1'b1;
            if (cmd_valid[g] && ready_q)
            begin
              ready_d = 1'b0;
              up_d = cmd[g].up;
              left_d = cmd[g].steps;
              store_d = cmd[g].store;
              if (cmd[g].steps == 5'h00 && !cmd[g].store)
              begin
                // nothing to move or keep: a select could only store,
                // so select and strobe stay put, the direction pin still takes up, and the channel just waits
                cnt_d = CW'(DESEL_CYC);
                st_d = ST_WAIT;
              end
              else
              begin
                sel_n_d = 1'b0;
                cnt_d = CW'(SETUP_CYC);
                st_d = ST_SEL;
              end
            end
          end
          ST_SEL:
            if (cnt_q == '0)
            begin
              if (step_n_q == 1'b0)
              begin
                // strobe parked low by a no-store deselect: lift it while
                // selected, a rising edge does not move the wiper
                step_n_d = 1'b1;
                cnt_d = CW'(HALF_CYC);
              end
              else if (left_q == 5'h00)
              begin
                cnt_d = CW'(HALF_CYC);
                st_d = ST_PRE;
              end
              else
              begin
                step_n_d = 1'b0;
                cnt_d = CW'(HALF_CYC);
                st_d = ST_LOW;
                if (up_q && pos_q != `DPC_POS_MAX)
                  pos_d = pos_q + 5'h01;
                else if (!up_q && pos_q != 5'h00)
                  pos_d = pos_q - 5'h01;
                left_d = left_q - 5'h01;
              end
            end
          ST_LOW:
            if (cnt_q == '0)
            begin
              if (left_q == 5'h00 && !store_q)
              begin
                // last step of a no-store command: the strobe stays low
                // while select rises, so the move is kept unstored
                cnt_d = CW'(HALF_CYC);
                st_d = ST_DESEL;
              end
              else
              begin
                step_n_d = 1'b1;
                cnt_d = CW'(HALF_CYC);
                st_d = ST_HIGH;
              end
            end
          ST_HIGH:
            if (cnt_q == '0)
            begin
              cnt_d = '0;
              st_d = ST_SEL;
            end
          ST_PRE:
            if (cnt_q == '0)
            begin
              // only storing commands get here; strobe high at deselect
              step_n_d = 1'b1;
              cnt_d = CW'(SETUP_CYC);
              st_d = ST_DESEL;
            end
          ST_DESEL:
            if (cnt_q == '0)
            begin
              sel_n_d = 1'b1;
              cnt_d = store_q ? CW'(STORE_CYC) : CW'(DESEL_CYC);
              if (store_q)
                known_d = 1'b1;
              st_d = ST_WAIT;
            end
          ST_WAIT:
            if (cnt_q == '0)
              st_d = ST_IDLE;
          default:
            st_d = ST_IDLE;
        endcase
      end

      // registers of one channel; select high from reset
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          st_q <= ST_IDLE;
          cnt_q <= '0;
          left_q <= 5'h00;
          up_q <= 1'b0;
          store_q <= 1'b0;
          sel_n_q <= 1'b1;
          step_n_q <= 1'b1;
          pos_q <= 5'h00;
          known_q <= 1'b0;
          ready_q <= 1'b0;
        end
        else
        begin
          st_q <= st_d;
          cnt_q <= cnt_d;
          left_q <= left_d;
          up_q <= up_d;
          store_q <= store_d;
          sel_n_q <= sel_n_d;
          step_n_q <= step_n_d;
          pos_q <= pos_d;
          known_q <= known_d;
          ready_q <= ready_d;
        end
      end

      assign pins[g].sel_n = sel_n_q;
      assign pins[g].step_n = step_n_q;
      assign pins[g].up = up_q;
      assign cmd_ready[g] = ready_q;
      assign pos_known[g] = known_q;
      assign pos[g*5 +: 5] = pos_q;
    end
  endgenerate
endmodule

// file: dpc_pot_model.sv
// Purpose: behavioural dual wiper counter with position store
// Assumes: pins come from dpc_host
// Notes: store is instant; INIT is the recalled value
`timescale 1ns/1ps
module dpc_pot_model import dpc_pkg::*;
#(
  parameter logic [4:0] INIT = 5'h0C
)
(
  // host pins
  input dpc_pins_t pins [2],
  // counter, tap decode, store
  output logic [4:0] cnt [2],
  output logic [31:0] tap [2],
  output logic [4:0] nv [2]
);
  // one independent section per channel
  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    // recall at power-up
    initial
    begin
      nv[g] = INIT;
      cnt[g] = INIT;
    end
    // falling strobe steps only while selected, saturating
    always @(negedge pins[g].step_n)
      if (pins[g].sel_n === 1'b0)
        if (pins[g].up)
          cnt[g] = cnt[g] + 5'(cnt[g] != 5'h1F);
        else
          cnt[g] = cnt[g] - 5'(cnt[g] != 5'h00);
    // deselect stores only with strobe high
    always @(posedge pins[g].sel_n)
      if (pins[g].step_n === 1'b1)
        nv[g] = cnt[g];
    assign tap[g] = 32'h1 << cnt[g];
  end
endmodule

// file: dpc_host_checker.sv
// Purpose: pin sequencing checks on channel 0
// Assumes: bound to dpc_host
// Notes: STORE_CYC is handed on by the bind
`timescale 1ns/1ps
module dpc_host_checker import dpc_pkg::*;
#(
  parameter int STORE_CYC = 100
)
(
  // clock, reset, handshake
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] cmd_valid,
  input dpc_cmd_t cmd [2],
  input wire logic [1:0] cmd_ready,
  // device pins
  input dpc_pins_t pins [2]
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] hi_q;
  logic st_q;
  logic keep_q;
  sequence s_take;
    cmd_valid[0] && cmd_ready[0];
  endsequence
  sequence s_desel;
    $rose(pins[0].sel_n);
  endsequence
  // deselected time, last deselect kind, requested store
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      hi_q <= '0;
      st_q <= 1'b0;
      keep_q <= 1'b0;
    end
    else
    begin
      hi_q <= pins[0].sel_n ? hi_q + 1 : '0;
      if ($rose(pins[0].sel_n))
        st_q <= pins[0].step_n;
      if (cmd_valid[0] && cmd_ready[0])
        keep_q <= cmd[0].store;
    end
  AST_IDLE_DESEL: assert property (cmd_ready[0] |-> pins[0].sel_n)
    else $error("select low while idle");
  AST_DIR_SET: assert property (s_take |=>
    pins[0].up == $past(cmd[0].up) &&
    pins[0].sel_n == ($past(cmd[0].steps) == 5'h00 && !$past(cmd[0].store)))
    else $error("direction not applied at select");
  AST_NO_RACE: assert property (s_desel |-> !$fell(pins[0].step_n))
    else $error("strobe fell with select rise");
  AST_DIR_HOLD: assert property ($fell(pins[0].step_n) |->
    !pins[0].sel_n && $past(pins[0].up, 20) == pins[0].up)
    else $error("direction moved near step");
  AST_NOSTORE: assert property (s_desel |-> pins[0].step_n == keep_q)
    else $error("strobe level wrong at deselect");
  AST_STORE_GAP: assert property ($fell(pins[0].sel_n) && st_q |->
    hi_q >= STORE_CYC)
    else $error("reselect too soon after store");
endmodule
bind dpc_host dpc_host_checker #(.STORE_CYC(STORE_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .pins(pins));

// file: dpc_host_bench.sv
// Purpose: random commands against the pot model, scoreboarded
// Assumes: HALF_CYC and STORE_CYC shortened
// Notes: each command notes expected counter and store
`timescale 1ns/1ps
module dpc_host_bench import dpc_pkg::*;;
  typedef struct packed {
    logic ch;
    logic [4:0] c;
    logic [4:0] v;
    logic [4:0] p;
    logic k;
  } dpc_note_t;
  logic core_clk = 0;
  logic rst = 1;
  logic [1:0] cmd_valid = '0;
  logic [1:0] rdy_q = '0;
  dpc_cmd_t cmd [2];
  logic [1:0] cmd_ready, pos_known;
  logic [9:0] pos;
  dpc_pins_t pins [2];
  logic [4:0] cnt [2], nv [2], e_c [2], e_v [2], e_p [2];
  logic e_k [2];
  logic [31:0] tap [2];
  dpc_note_t q [$];
  dpc_note_t m;
  int error_cnt = 0, num_checks = 0, seed = 78206;
  dpc_host #(.STORE_CYC(100), .HALF_CYC(25)) dut (.core_clk(core_clk),
    .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .pos_known(pos_known), .pos(pos), .pins(pins));
  dpc_pot_model u_pot (.pins(pins), .cnt(cnt), .tap(tap), .nv(nv));
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait until both channels are idle
  task automatic wait_idle;
    for (int n = 0; cmd_ready !== 2'b11; n++)
    begin
      @(posedge core_clk);
      if (n > 5000)
      begin
        error_cnt++;
        tally_and_finish;
      end
    end
  endtask
  // one saturating step of a 5-bit position
  function automatic logic [4:0] sat_step(logic [4:0] v, logic u);
    if (u)
      return v + 5'(v != 5'h1F);
    return v - 5'(v != 5'h00);
  endfunction
  // note the expected result, then hand one command over
  task automatic send(logic ch, logic u, logic [4:0] s, logic st);
    for (int i = 0; i < s; i++)
    begin
      e_c[ch] = sat_step(e_c[ch], u);
      e_p[ch] = sat_step(e_p[ch], u); // host mirror starts from zero
    end
    if (st)
    begin
      e_v[ch] = e_c[ch];
      e_k[ch] = 1'b1;
    end
    q.push_back({ch, e_c[ch], e_v[ch], e_p[ch], e_k[ch]});
    wait_idle;
    cmd_valid[ch] <= 1'b1;
    cmd[ch] <= {u, s, st};
    @(posedge core_clk);
    cmd_valid[ch] <= 1'b0;
    @(posedge core_clk);
  endtask
  // on each return to idle compare the device against the oldest note
  always @(posedge core_clk)
  begin
    rdy_q <= cmd_ready;
    if ((cmd_ready & ~rdy_q) != 2'b00 && q.size() > 0)
    begin
      m = q.pop_front();
      chk("wiper", 32'(m.c), 32'(cnt[m.ch]));
      chk("tap", 32'h1 << m.c, tap[m.ch]);
      chk("store", 32'(m.v), 32'(nv[m.ch]));
      chk("mirror", 32'(m.p), 32'(pos[m.ch*5 +: 5]));
      chk("known", 32'(m.k), 32'(pos_known[m.ch]));
    end
  end
  initial
  begin
    int r;
    cmd[0] = '0;
    cmd[1] = '0;
    e_c = '{5'h0C, 5'h0C};
    e_v = '{5'h0C, 5'h0C};
    e_p = '{5'h00, 5'h00};
    e_k = '{1'b0, 1'b0};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // let the ready rise after reset pass before the first note is queued
    repeat (3) @(posedge core_clk);
    send(0, 1, 31, 0);
    send(0, 0, 31, 1);
    send(1, 1, 3, 0);
    repeat (14)
    begin
      r = $random(seed);
      send(r[0], r[1], r[6:2], r[7]);
    end
    wait_idle;
    repeat (4) @(posedge core_clk);
    chk("left", 32'h0, 32'(q.size()));
    tally_and_finish;
  end
endmodule
